/* core/adc_conv_ctrl.sv */
// Successive-approximation converter control with AXI4-Lite registers
`timescale 1ns/10ps
module adc_conv_ctrl (
	// Clock and reset
	input  wire logic                               CLK,
	input  wire logic                               RST_B,
	// AXI4-Lite write address and data
	input  wire logic [adc_ctrl_pkg::ADDR_W-1:0]    AWADDR,
	input  wire logic                               AWVALID,
	output logic                                    AWREADY,
	input  wire logic [adc_ctrl_pkg::DATA_W-1:0]    WDATA,
	input  wire logic [3:0]                         WSTRB,
	input  wire logic                               WVALID,
	output logic                                    WREADY,
	// AXI4-Lite write response
	output logic [1:0]                              BRESP,
	output logic                                    BVALID,
	input  wire logic                               BREADY,
	// AXI4-Lite read
	input  wire logic [adc_ctrl_pkg::ADDR_W-1:0]    ARADDR,
	input  wire logic                               ARVALID,
	output logic                                    ARREADY,
	output logic [adc_ctrl_pkg::DATA_W-1:0]         RDATA,
	output logic [1:0]                              RRESP,
	output logic                                    RVALID,
	input  wire logic                               RREADY,
	// System state and analog side
	input  wire logic                               SLEEP,
	input  wire logic                               COMPARE,
	input  wire logic                               RC_OSC,
	output logic [adc_ctrl_pkg::CHAN_W-1:0]         CHANNEL_SEL,
	output logic                                    REF_EXT_SEL,
	output logic                                    SAMPLE_HOLD,
	output logic                                    CONV_POWER,
	output logic [adc_ctrl_pkg::RES_W-1:0]          DAC_TRIAL,
	// Interrupt and wake
	output logic                                    IRQ,
	output logic                                    WAKE
);
	import adc_ctrl_pkg::*;

	// ============================================================
	// Declarations
	conv_state_e         st_q;
	conv_state_e         st_d;
	logic                en_q;
	logic                go_q;
	logic                pref_q;
	logic                just_q;
	logic                flag_q;
	logic                flag_d;
	logic                irqen_q;
	logic                last_q;
	logic                soff_q;
	logic                soff_d;
	logic [CHAN_W-1:0]   chan_q;
	logic [CSEL_W-1:0]   csel_q;
	logic [RES_W-1:0]    sar_q;
	logic [RES_W-1:0]    res_q;
	logic [RES_W-1:0]    sar_upd;
	logic [RES_W-1:0]    sar_fill;
	logic [BIT_W-1:0]    bit_q;
	logic [HCNT_W-1:0]   hcnt_q;
	logic [DLY_W-1:0]    dly_q;
	logic                awready_q;
	logic                bvalid_q;
	logic [1:0]          bresp_q;
	logic                arready_q;
	logic                rvalid_q;
	logic [1:0]          rresp_q;
	logic [DATA_W-1:0]   rdata_q;
	logic                hold_q;
	logic                pwr_q;
	logic                irq_q;
	logic                wake_q;
	logic                cmp_s;
	logic                rc_s;
	logic                tick;

	// ============================================================
	// Input synchroniser and conversion clock
	sync2 #(.W(1)) u_sync (
		.clk   (CLK),
		.rst_b (RST_B),
		.d     (RC_OSC),
		.q     (rc_s)
	);
	// Comparator follows the trial register; sync flops would miss a Fosc/2 bit
	assign cmp_s = COMPARE;

	conv_clk_gen u_clk (
		.clk    (CLK),
		.rst_b  (RST_B),
		.run    (st_q == ST_CONV),
		.csel   (csel_q),
		.rc_lvl (rc_s),
		.tick_q (tick)
	);

	// ============================================================
	// Register decode
	wire aw_go   = AWVALID && WVALID && !awready_q && !bvalid_q;
	wire ar_go   = ARVALID && !arready_q && !rvalid_q;
	wire wr_fire = awready_q && WSTRB[0];
	wire wr_c0   = wr_fire && AWADDR == OFF_CTRL0;
	wire wr_c1   = wr_fire && AWADDR == OFF_CTRL1;
	wire wr_st   = wr_fire && AWADDR == OFF_STATUS;
	wire wr_mk   = wr_fire && AWADDR == OFF_MASK;
	wire w_hit   = AWADDR == OFF_CTRL0 || AWADDR == OFF_CTRL1 || AWADDR == OFF_RESULT
		|| AWADDR == OFF_STATUS || AWADDR == OFF_MASK;
	wire r_hit   = ARADDR == OFF_CTRL0 || ARADDR == OFF_CTRL1 || ARADDR == OFF_RESULT
		|| ARADDR == OFF_STATUS || ARADDR == OFF_MASK;
	wire w_en    = WDATA[C0_EN];
	wire w_go    = WDATA[C0_GO];

	// ============================================================
	// Conversion control terms
	wire rc_sel  = csel_q[1:0] == CSEL_RC;
	wire busy    = st_q != ST_IDLE;
	// start needs enable; enable must already be on
	wire start   = wr_c0 && w_go && w_en && en_q && !busy && !soff_q;
	// software clear of start stops the conversion
	wire sw_abort = busy && wr_c0 && !(w_go && w_en);
	// sleep on a divided clock aborts
	wire sl_abort = busy && SLEEP && !rc_sel;
	wire last_tk = st_q == ST_CONV && tick && hcnt_q == HALF_LAST;
	// one decision per bit period after the 1.5-period lead
	wire decide  = st_q == ST_CONV && tick && hcnt_q >= FIRST_DEC && !hcnt_q[0];
	wire done    = last_tk && !sw_abort && !sl_abort;
	wire stop    = sw_abort || sl_abort || done;

	// Per-bit trial update and partial-result fill
	for (genvar i = 0; i < RES_W; i++) begin : g_bit
		assign sar_upd[i]  = (BIT_W'(i) == bit_q) ? cmp_s
			: ((BIT_W'(i + 1) == bit_q) ? 1'b1 : sar_q[i]);
		// unconverted bits copy the last decision
		assign sar_fill[i] = (BIT_W'(i) > bit_q) ? sar_q[i] : last_q;
	end

	// ============================================================
	// State machine
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			ST_IDLE: begin
				// RC clock adds one instruction cycle
				if (start) st_d = rc_sel ? ST_DELAY : ST_CONV;
			end
			ST_DELAY: begin
				if (dly_q == DLY_LAST) st_d = ST_CONV;
			end
			ST_CONV: begin
				if (last_tk) st_d = ST_IDLE;
			end
		endcase
		if (stop) st_d = ST_IDLE;
	end

	// completion sets flag; only software clears
	assign flag_d = done || (flag_q && !(wr_st && WDATA[ST_DONE]));
	// power down in sleep on a divided clock, or on the RC clock after completion without interrupt
	assign soff_d = SLEEP && (soff_q || !rc_sel || (done && !irqen_q));

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			st_q   <= ST_IDLE;
			dly_q  <= '0;
			hcnt_q <= '0;
		end else begin
			st_q   <= st_d;
			dly_q  <= (st_q == ST_DELAY) ? dly_q + 3'h1 : '0;
			hcnt_q <= (st_q != ST_CONV) ? '0 : (tick ? hcnt_q + 5'h01 : hcnt_q);
		end
	end

	// ============================================================
	// Successive approximation register
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			sar_q  <= '0;
			bit_q  <= '0;
			last_q <= 1'b0;
		end else if (start) begin
			sar_q  <= TRIAL_INIT;
			bit_q  <= BIT_W'(RES_W - 1);
			last_q <= 1'b0;
		end else if (decide) begin
			sar_q  <= sar_upd;
			bit_q  <= bit_q - 4'h1;
			last_q <= cmp_s;
		end
	end

	// Result latch
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			res_q <= '0;
		end else if (done) begin
			res_q <= sar_upd;
		end else if (sw_abort) begin
			res_q <= sar_fill;
		end
	end

	// ============================================================
	// Control registers
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			en_q    <= 1'b0;
			chan_q  <= '0;
			pref_q  <= 1'b0;
			csel_q  <= '0;
			just_q  <= 1'b0;
			irqen_q <= 1'b0;
		end else begin
			if (wr_c0) en_q <= w_en;
			// channel code for the input mux
			if (wr_c0) chan_q <= WDATA[C0_CHAN_LO +: CHAN_W];
			if (wr_c1) pref_q <= WDATA[C1_PREF];
			if (wr_c1) csel_q <= WDATA[C1_CSEL_LO +: CSEL_W];
			if (wr_c1) just_q <= WDATA[C1_JUST];
			if (wr_mk) irqen_q <= WDATA[ST_DONE];
		end
	end

	// Busy bit, flag, power and outputs
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			go_q   <= 1'b0;
			flag_q <= 1'b0;
			soff_q <= 1'b0;
			hold_q <= 1'b0;
			pwr_q  <= 1'b0;
			irq_q  <= 1'b0;
			wake_q <= 1'b0;
		end else begin
			go_q   <= start || (go_q && !stop);
			flag_q <= flag_d;
			soff_q <= soff_d;
			hold_q <= st_d == ST_CONV;
			// module off in sleep on a divided clock, or on the RC clock after completion without interrupt; enable bit kept
			pwr_q  <= en_q && !soff_q;
			irq_q  <= flag_q && irqen_q;
			wake_q <= SLEEP && flag_q && irqen_q;
		end
	end

	// ============================================================
	// Read data
	// justification of the result word
	wire [DATA_W-1:0] rv_res = just_q ? DATA_W'({res_q, {RES_PAD{1'b0}}})
		: DATA_W'(res_q);
	wire [DATA_W-1:0] rv_c0 = DATA_W'({chan_q, go_q, en_q});
	wire [DATA_W-1:0] rv_c1 = DATA_W'({just_q, csel_q, 3'h0, pref_q});
	wire [DATA_W-1:0] rv    = (ARADDR == OFF_CTRL0) ? rv_c0
		: (ARADDR == OFF_CTRL1) ? rv_c1
		: (ARADDR == OFF_RESULT) ? rv_res
		: (ARADDR == OFF_STATUS) ? DATA_W'(flag_q)
		: (ARADDR == OFF_MASK) ? DATA_W'(irqen_q) : '0;

	// ============================================================
	// AXI4-Lite handshakes
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			awready_q <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rresp_q   <= RESP_OKAY;
			rdata_q   <= '0;
		end else begin
			awready_q <= aw_go;
			if (awready_q) begin
				bvalid_q <= 1'b1;
				bresp_q  <= w_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (BREADY) begin
				bvalid_q <= 1'b0;
			end
			arready_q <= ar_go;
			if (arready_q) begin
				rvalid_q <= 1'b1;
				rdata_q  <= rv;
				rresp_q  <= r_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (RREADY) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	assign AWREADY     = awready_q;
	assign WREADY      = awready_q;
	assign BVALID      = bvalid_q;
	assign BRESP       = bresp_q;
	assign ARREADY     = arready_q;
	assign RVALID      = rvalid_q;
	assign RRESP       = rresp_q;
	assign RDATA       = rdata_q;
	assign CHANNEL_SEL = chan_q;
	assign REF_EXT_SEL = pref_q;
	assign SAMPLE_HOLD = hold_q;
	assign CONV_POWER  = pwr_q;
	assign DAC_TRIAL   = sar_q;
	assign IRQ         = irq_q;
	assign WAKE        = wake_q;

	// ============================================================
	// Checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);

	sequence rc_start_s;
		start && rc_sel;
	endsequence

	sequence delay_run_s;
		(st_q == ST_DELAY) [*4];
	endsequence

	done_sets_flag_a: assert property (done |=> flag_q && !go_q && st_q == ST_IDLE)
		else $error("completion did not set flag and clear busy");
	flag_sticky_a: assert property (flag_q && !wr_st |=> flag_q)
		else $error("done flag cleared without software write");
	irq_gate_a: assert property ($rose(IRQ) |-> $past(irqen_q) && $past(flag_q))
		else $error("interrupt raised while disabled");
	busy_reads_a: assert property (busy |-> go_q)
		else $error("busy bit low during conversion");
	rc_delay_a: assert property (rc_start_s ##1 delay_run_s |=> st_q != ST_DELAY)
		else $error("RC start delay too long");
	off_idle_a: assert property (!en_q && !busy |=> !busy)
		else $error("conversion started while disabled");
	sleep_abort_a: assert property (sl_abort |=> st_q == ST_IDLE && $stable(en_q))
		else $error("sleep did not abort divided-clock conversion");
	abort_fill_a: assert property (sw_abort && !decide && last_q |=> res_q[0])
		else $error("partial result fill wrong");
	conv_len_a: assert property (st_q == ST_CONV |-> hcnt_q <= HALF_LAST)
		else $error("conversion ran past its length");
endmodule

/* core/adc_ctrl_pkg.sv */
// Shared constants and types of the converter control block
package adc_ctrl_pkg;

	// ============================================================
	// Bus
	localparam int          ADDR_W      = 8;
	localparam int          DATA_W      = 32;
	localparam logic [7:0]  OFF_CTRL0   = 8'h00;
	localparam logic [7:0]  OFF_CTRL1   = 8'h04;
	localparam logic [7:0]  OFF_RESULT  = 8'h08;
	localparam logic [7:0]  OFF_STATUS  = 8'h0C;
	localparam logic [7:0]  OFF_MASK    = 8'h10;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// ============================================================
	// Fields
	localparam int          C0_EN       = 0;
	localparam int          C0_GO       = 1;
	localparam int          C0_CHAN_LO  = 2;
	localparam int          CHAN_W      = 5;
	localparam int          NUM_SOURCES = 11;
	localparam int          C1_PREF     = 0;
	localparam int          C1_CSEL_LO  = 4;
	localparam int          CSEL_W      = 3;
	localparam int          C1_JUST     = 7;
	localparam int          ST_DONE     = 0;
	localparam logic [1:0]  CSEL_RC     = 2'h3;

	// ============================================================
	// Conversion
	localparam int          RES_W       = 10;
	localparam int          RES_PAD     = 6;
	localparam int          BIT_W       = 4;
	localparam int          HCNT_W      = 5;
	localparam int          DLY_W       = 3;
	localparam logic [9:0]  TRIAL_INIT  = 10'h200;
	localparam logic [4:0]  HALF_LAST   = 5'h16;
	localparam logic [4:0]  FIRST_DEC   = 5'h04;

	// ============================================================
	// Timing
	localparam int          CLK_PERIOD_NS  = 4;
	localparam int          INSTR_CYCLE_NS = 16;
	localparam int          INSTR_CYCLES   = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0]  DLY_LAST       = 3'(INSTR_CYCLES - 1);

	typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONV} conv_state_e;

endpackage

/* core/conv_clk_gen.sv */
// Half bit-period tick generator for the conversion clock
`timescale 1ns/10ps
module conv_clk_gen (
	// Clock and reset
	input  wire logic                           clk,
	input  wire logic                           rst_b,
	// Control
	input  wire logic                           run,
	input  wire logic [adc_ctrl_pkg::CSEL_W-1:0] csel,
	input  wire logic                           rc_lvl,
	// Tick
	output logic                                tick_q
);
	import adc_ctrl_pkg::*;

	logic [5:0] cnt_q;
	logic       rc_prev_q;
	logic [2:0] shamt;
	logic [5:0] half_m1;
	logic       rc_mode;
	logic       div_hit;
	logic       rc_edge;

	// ============================================================
	// Divider select
	// clock code decode
	assign rc_mode = csel[1:0] == CSEL_RC;
	assign shamt   = {csel[1:0], 1'b0} + {2'h0, csel[2]};
	assign half_m1 = 6'((7'h01 << shamt) - 7'h01);
	// divided ticks follow CLK, RC ticks do not
	assign div_hit = cnt_q == half_m1;
	assign rc_edge = rc_lvl ^ rc_prev_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q     <= '0;
			rc_prev_q <= 1'b0;
			tick_q    <= 1'b0;
		end else begin
			cnt_q     <= (!run || div_hit) ? 6'h00 : cnt_q + 6'h01;
			rc_prev_q <= rc_lvl;
			tick_q    <= run && (rc_mode ? rc_edge : div_hit);
		end
	end
endmodule

/* core/sync2.sv */
// Two-flop synchroniser for asynchronous inputs
`timescale 1ns/10ps
module sync2 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule

/* sim/sar_analog_model.sv */
// Behavioural sample-hold and comparator on the far side of the converter
`timescale 1ns/10ps
module sar_analog_model (
	// Clock
	input  wire logic                          clk,
	// Analog controls from the block
	input  wire logic [adc_ctrl_pkg::CHAN_W-1:0] chan,
	input  wire logic                          ref_ext,
	input  wire logic                          hold,
	input  wire logic                          power,
	input  wire logic [adc_ctrl_pkg::RES_W-1:0]  trial,
	// Comparator result
	output logic                               cmp
);
	import adc_ctrl_pkg::*;
	logic [RES_W-1:0] held_q = 10'h000;
	logic             junk_q = 1'b0;
	// ============================================================
	// Sample
	// source level captured
	always @(posedge hold) begin
		held_q = {chan, 5'h00} + (ref_ext ? 10'h003 : 10'h011);
	end
	// Unpowered comparator output wanders
	always @(posedge clk) begin
		junk_q <= ~junk_q;
	end
	assign cmp = power ? (held_q >= trial) : junk_q;
endmodule

/* sim/tb.sv */
// Self-checking bench for the converter control block
`timescale 1ns/10ps
module tb;
	import adc_ctrl_pkg::*;
	typedef struct {
		logic [4:0]  ch;
		logic        pref;
		logic [2:0]  cs;
		logic        just;
		logic        mask;
		logic [15:0] res;
	} row_s;
	logic        CLK, RST_B, AWVALID, WVALID, BREADY, ARVALID, RREADY, SLEEP, RC_OSC;
	logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, COMPARE;
	logic        REF_EXT_SEL, SAMPLE_HOLD, CONV_POWER, IRQ, WAKE;
	logic [7:0]  AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA, rd;
	logic [3:0]  WSTRB;
	logic [1:0]  BRESP, RRESP, rsp;
	logic [4:0]  CHANNEL_SEL;
	logic [9:0]  DAC_TRIAL;
	int          err_total, compares, i, n;
	row_s        r;
	row_s        rows [8] = '{
		'{5'h00, 1'b0, 3'h0, 1'b0, 1'b1, 16'h0011},
		'{5'h03, 1'b1, 3'h4, 1'b1, 1'b0, 16'h18C0},
		'{5'h0A, 1'b0, 3'h1, 1'b0, 1'b1, 16'h0151},
		'{5'h05, 1'b1, 3'h5, 1'b0, 1'b0, 16'h00A3},
		'{5'h1F, 1'b0, 3'h2, 1'b1, 1'b1, 16'hFC40},
		'{5'h01, 1'b0, 3'h6, 1'b0, 1'b0, 16'h0031},
		'{5'h07, 1'b1, 3'h3, 1'b1, 1'b1, 16'h38C0},
		'{5'h14, 1'b0, 3'h7, 1'b0, 1'b0, 16'h0291}};
	// ============================================================
	// Design and far side
	adc_conv_ctrl adc_conv_ctrl_inst (.CLK(CLK), .RST_B(RST_B), .AWADDR(AWADDR),
		.AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
		.WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
		.BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
		.RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
		.SLEEP(SLEEP), .COMPARE(COMPARE), .RC_OSC(RC_OSC), .CHANNEL_SEL(CHANNEL_SEL),
		.REF_EXT_SEL(REF_EXT_SEL), .SAMPLE_HOLD(SAMPLE_HOLD), .CONV_POWER(CONV_POWER),
		.DAC_TRIAL(DAC_TRIAL), .IRQ(IRQ), .WAKE(WAKE));
	sar_analog_model sar_analog_model_inst (.clk(CLK), .chan(CHANNEL_SEL),
		.ref_ext(REF_EXT_SEL), .hold(SAMPLE_HOLD), .power(CONV_POWER),
		.trial(DAC_TRIAL), .cmp(COMPARE));
	// ============================================================
	// Clocks
	initial begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end
	initial begin
		RC_OSC = 1'b0;
		forever #9 RC_OSC = ~RC_OSC;
	end
	// ============================================================
	// Tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge CLK);
		AWADDR  <= a;
		WDATA   <= d;
		AWVALID <= 1'b1;
		WVALID  <= 1'b1;
		BREADY  <= 1'b1;
		do @(negedge CLK); while (AWREADY !== 1'b1 && ++k < 999);
		@(posedge CLK);
		AWVALID <= 1'b0;
		WVALID  <= 1'b0;
		do @(negedge CLK); while (BVALID !== 1'b1 && ++k < 999);
		rsp = BRESP;
		if (k >= 999) err_total++;
		@(posedge CLK);
		BREADY <= 1'b0;
	endtask
	task automatic rd_(input logic [7:0] a);
		int k;
		k = 0;
		@(posedge CLK);
		ARADDR  <= a;
		ARVALID <= 1'b1;
		RREADY  <= 1'b1;
		do @(negedge CLK); while (ARREADY !== 1'b1 && ++k < 999);
		@(posedge CLK);
		ARVALID <= 1'b0;
		do @(negedge CLK); while (RVALID !== 1'b1 && ++k < 999);
		rd  = RDATA;
		rsp = RRESP;
		if (k >= 999) err_total++;
		@(posedge CLK);
		RREADY <= 1'b0;
	endtask
	task automatic wait_done;
		int k;
		k = 0;
		do rd_(OFF_CTRL0); while (rd[C0_GO] !== 1'b0 && ++k < 3000);
		if (k >= 3000) err_total++;
	endtask
	task automatic tally_and_finish;
		if (err_total == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		#100000;
		err_total++;
		tally_and_finish();
	end
	// ============================================================
	// Main sequence
	initial begin
		{RST_B, AWVALID, WVALID, BREADY, ARVALID, RREADY, SLEEP} = 7'h00;
		{AWADDR, ARADDR, WDATA, WSTRB} = 52'h0;
		err_total = 0;
		compares = 0;
		repeat (10) @(posedge CLK);
		RST_B <= 1'b1;
		WSTRB <= 4'hF;
		for (i = 0; i < 8; i++) begin
			r = rows[i];
			wr(OFF_MASK, 32'(r.mask));
			wr(OFF_CTRL1, {24'h0, r.just, r.cs, 3'h0, r.pref});
			wr(OFF_CTRL0, {25'h0, r.ch, 2'h1});
			chk(32'(CHANNEL_SEL), 32'(r.ch));
			chk(32'(REF_EXT_SEL), 32'(r.pref));
			wr(OFF_CTRL0, {25'h0, r.ch, 2'h3});
			rd_(OFF_CTRL0);
			chk(32'(rd[C0_GO]), 32'h1);
			chk(32'(SAMPLE_HOLD), 32'h1);
			wait_done();
			rd_(OFF_STATUS);
			chk(rd, 32'h1);
			chk(32'(SAMPLE_HOLD), 32'h0);
			chk(32'(IRQ), 32'(r.mask));
			rd_(OFF_RESULT);
			chk(rd, 32'(r.res));
			wr(OFF_STATUS, 32'h1);
			rd_(OFF_STATUS);
			chk(rd, 32'h0);
		end
		wr(OFF_CTRL0, 32'h0);
		wr(OFF_CTRL0, 32'h3);
		rd_(OFF_CTRL0);
		chk(rd, 32'h1);
		wr(OFF_MASK, 32'h0);
		wr(OFF_CTRL1, 32'h60);
		wr(OFF_CTRL0, 32'h7D);
		wr(OFF_CTRL0, 32'h7F);
		repeat (450) @(posedge CLK);
		wr(OFF_CTRL0, 32'h7D);
		rd_(OFF_RESULT);
		chk(rd, 32'h3FF);
		wr(OFF_STATUS, 32'h1);
		wr(OFF_CTRL0, 32'h7F);
		repeat (100) @(posedge CLK);
		SLEEP <= 1'b1;
		repeat (4) @(posedge CLK);
		chk(32'(CONV_POWER), 32'h0);
		rd_(OFF_CTRL0);
		chk(rd, 32'h7D);
		rd_(OFF_STATUS);
		chk(rd, 32'h0);
		SLEEP <= 1'b0;
		wr(OFF_MASK, 32'h1);
		wr(OFF_CTRL1, 32'h70);
		wr(OFF_CTRL0, 32'h7F);
		SLEEP <= 1'b1;
		n = 0;
		do @(negedge CLK); while (WAKE !== 1'b1 && ++n < 3000);
		chk(32'(WAKE), 32'h1);
		SLEEP <= 1'b0;
		rd_(OFF_RESULT);
		chk(rd, 32'h3F1);
		wr(OFF_STATUS, 32'h1);
		wr(OFF_MASK, 32'h0);
		wr(OFF_CTRL0, 32'h7F);
		SLEEP <= 1'b1;
		wait_done();
		repeat (2) @(posedge CLK);
		chk(32'(CONV_POWER), 32'h0);
		chk(32'(WAKE), 32'h0);
		rd_(OFF_CTRL0);
		chk(rd, 32'h7D);
		SLEEP <= 1'b0;
		wr(8'h20, 32'h1);
		chk(32'(rsp), 32'(RESP_SLVERR));
		rd_(8'h20);
		chk({rd[29:0], rsp}, 32'(RESP_SLVERR));
		wr(OFF_CTRL1, 32'h60);
		wr(OFF_CTRL0, 32'h7F);
		repeat (50) @(posedge CLK);
		RST_B <= 1'b0;
		repeat (3) @(posedge CLK);
		RST_B <= 1'b1;
		@(posedge CLK);
		chk(32'(CONV_POWER), 32'h0);
		for (i = 0; i < 5; i++) begin
			rd_(8'(i * 4));
			chk(rd, 32'h0);
		end
		tally_and_finish();
	end
endmodule
